// *** rtl/goh_pkg.sv ***
// Contract
// - Offset adds to gear setpoint in gear mode
// - Writing an offset target starts traverse
// - Offsets are encoder increments, absolute or relative
// - Leaving gear mode aborts running offset
// - Mode 0 jumps, mode 1 ramps
// - Gear processing off: offset merged immediately
// - Scale preset redefines offset scale, no move
// - Offset goal readable as absolute increments
// - Target speed 1..12000 rpm, default 60
// - Acceleration 60..2000000, default 300
// - Deceleration separate setting, default 300
// - Absolute target INT32, default 0, starts move
// - Relative distance INT32, default 0, starts move
// - Motion writes act at once
// - Reference by reference move or dimension set
// - Found reference point becomes origin
// - Dimension set takes motor position as origin
// - Referencing progress readable
// - Success sets reference-valid flag
// - Negative numerator reverses motor direction
package goh_pkg;
  localparam logic [7:0] IDX_GEAR = 8'h27;
  localparam logic [7:0] IDX_HOME = 8'h28;
  localparam logic [7:0] IDX_STAT = 8'h29;
  localparam logic [7:0] SIX_ABS = 8'h01;
  localparam logic [7:0] SIX_STATE = 8'h02;
  localparam logic [7:0] SIX_REL = 8'h03;
  localparam logic [7:0] SIX_SPEED = 8'h05;
  localparam logic [7:0] SIX_PRESET = 8'h06;
  localparam logic [7:0] SIX_ACC = 8'h07;
  localparam logic [7:0] SIX_DEC = 8'h08;
  localparam logic [7:0] SIX_MODE = 8'h09;
  localparam logic [7:0] SIX_HOME_START = 8'h01;
  localparam logic [7:0] SIX_SETP_START = 8'h02;
  localparam logic [7:0] SIX_HOME_STATE = 8'h03;
  localparam logic [7:0] SIX_ACT_MODE = 8'h04;
  localparam logic [7:0] SIX_GOAL = 8'h01;
  localparam logic [7:0] SIX_CUR = 8'h02;
  localparam logic [7:0] SIX_ABS_POS = 8'h03;
  localparam logic [31:0] SPEED_RST = 32'h0000003C;
  localparam logic [31:0] SPEED_MIN = 32'h00000001;
  localparam logic [31:0] SPEED_MAX = 32'h00002EE0;
  localparam logic [31:0] RAMP_RST = 32'h0000012C;
  localparam logic [31:0] RAMP_MIN = 32'h0000003C;
  localparam logic [31:0] RAMP_MAX = 32'h001E8480;
  localparam int ST_REACHED = 13;
  localparam int ST_END = 14;
  localparam int ST_ERR = 15;
  localparam int TICK_US = 1000;
  localparam int CLK_MHZ = 50;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam logic [47:0] INC_PER_REV = 48'h000000004000;
  localparam logic [47:0] MRPM_PER_RPM = 48'h0000000003E8;
  localparam logic [47:0] STEP_DIV = 48'h00000393_8700;
  localparam logic [95:0] BRAKE_K = 96'h000000000000000007270E00;

  typedef enum logic [3:0] {
    SEL_NONE = 4'h0, SEL_ABS = 4'h1, SEL_STATE = 4'h2, SEL_REL = 4'h3,
    SEL_SPEED = 4'h4, SEL_PRESET = 4'h5, SEL_ACC = 4'h6, SEL_DEC = 4'h7,
    SEL_MODE = 4'h8, SEL_HSTART = 4'h9, SEL_SSTART = 4'hA, SEL_HSTATE = 4'hB,
    SEL_ACT = 4'hC, SEL_GOAL = 4'hD, SEL_CUR = 4'hE, SEL_APOS = 4'hF
  } goh_sel_t;

  typedef enum logic [1:0] {
    OFF_IDLE = 2'b00, OFF_RAMP = 2'b01
  } goh_off_t;

  typedef enum logic [1:0] {
    HOME_IDLE = 2'b00, HOME_RUN = 2'b01
  } goh_home_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [7:0] six;
    logic [31:0] wdata;
  } goh_par_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } goh_par_rsp_t;

  typedef struct packed {
    logic [7:0] err_s1;
    logic [7:0] err_s2;
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic [15:0] mode;
    logic [31:0] speed;
    logic [31:0] acc;
    logic [31:0] dec;
    logic [31:0] abs_tgt;
    logic [31:0] rel_dist;
    logic [31:0] scale;
    logic [31:0] off_tgt;
    logic [31:0] off_cur;
    logic [15:0] status;
    goh_off_t off_st;
    logic [47:0] vel;
    logic [47:0] frac;
    logic [15:0] tick;
    logic [31:0] gear_acc;
    logic [31:0] origin;
    goh_home_t home_st;
    logic ref_ok;
    goh_par_rsp_t rsp;
    logic [31:0] setpoint;
  } goh_state_t;
endpackage

// *** rtl/goh_offset_homing.sv ***
`timescale 1ns/10ps
module goh_offset_homing import goh_pkg::*; #(
  parameter logic [15:0] TICK_CYCLES = 16'(TICK_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Parameter channel
  input wire goh_par_req_t par_req,
  output goh_par_rsp_t par_rsp,
  // Drive context
  input wire logic gear_active,
  input wire logic gear_proc_en,
  input wire logic gear_num_neg,
  input wire logic ref_step,
  input wire logic ref_step_dir,
  input wire logic [31:0] motor_pos,
  // Switch pins
  input wire logic [7:0] err_pins,
  input wire logic ref_switch,
  // Motion outputs
  output logic [31:0] pos_setpoint,
  output logic home_active,
  output logic ref_valid
);
  goh_state_t st_q, st_d;

  function automatic goh_sel_t reg_sel(input logic [7:0] idx, input logic [7:0] six);
    goh_sel_t s;
    s = SEL_NONE;
    if (idx == IDX_GEAR && six == SIX_ABS) s = SEL_ABS;
    else if (idx == IDX_GEAR && six == SIX_STATE) s = SEL_STATE;
    else if (idx == IDX_GEAR && six == SIX_REL) s = SEL_REL;
    else if (idx == IDX_GEAR && six == SIX_SPEED) s = SEL_SPEED;
    else if (idx == IDX_GEAR && six == SIX_PRESET) s = SEL_PRESET;
    else if (idx == IDX_GEAR && six == SIX_ACC) s = SEL_ACC;
    else if (idx == IDX_GEAR && six == SIX_DEC) s = SEL_DEC;
    else if (idx == IDX_GEAR && six == SIX_MODE) s = SEL_MODE;
    else if (idx == IDX_HOME && six == SIX_HOME_START) s = SEL_HSTART;
    else if (idx == IDX_HOME && six == SIX_SETP_START) s = SEL_SSTART;
    else if (idx == IDX_HOME && six == SIX_HOME_STATE) s = SEL_HSTATE;
    else if (idx == IDX_HOME && six == SIX_ACT_MODE) s = SEL_ACT;
    else if (idx == IDX_STAT && six == SIX_GOAL) s = SEL_GOAL;
    else if (idx == IDX_STAT && six == SIX_CUR) s = SEL_CUR;
    else if (idx == IDX_STAT && six == SIX_ABS_POS) s = SEL_APOS;
    return s;
  endfunction

  goh_sel_t wsel, rsel;
  logic start, jump;
  logic [31:0] new_tgt, diff;
  logic [32:0] rem;
  logic [47:0] vmax, step_sum, nsteps;
  logic [95:0] brake_lhs, brake_rhs;

  always_comb
  begin
    st_d = st_q;
    wsel = par_req.wr ? reg_sel(par_req.idx, par_req.six) : SEL_NONE;
    rsel = reg_sel(par_req.idx, par_req.six);
    start = 1'b0;
    new_tgt = st_q.off_tgt;
    diff = 32'h00000000;
    rem = 33'h000000000;
    vmax = 48'h000000000000;
    step_sum = 48'h000000000000;
    nsteps = 48'h000000000000;
    brake_lhs = 96'h0;
    brake_rhs = 96'h0;
    jump = !st_q.mode[0] || !gear_proc_en;
    // Switch inputs pass two flip-flops before anything looks at them.
    st_d.err_s1 = err_pins;
    st_d.err_s2 = st_q.err_s1;
    st_d.ref_s1 = ref_switch;
    st_d.ref_s2 = st_q.ref_s1;
    st_d.ref_s3 = st_q.ref_s2;
    // Reference increments follow the gear sign.
    if (ref_step)
    begin
      if (ref_step_dir ^ gear_num_neg)
        st_d.gear_acc = st_q.gear_acc - 32'h00000001;
      else
        st_d.gear_acc = st_q.gear_acc + 32'h00000001;
    end
    // Parameter channel: every access is answered the next cycle.
    st_d.rsp.ack = par_req.wr || par_req.rd;
    st_d.rsp.err = 1'b0;
    st_d.rsp.rdata = 32'h00000000;
    if (par_req.rd)
    begin
      case (rsel)
        SEL_ABS: st_d.rsp.rdata = st_q.abs_tgt;
        SEL_STATE: st_d.rsp.rdata = {16'h0000, st_q.status};
        SEL_REL: st_d.rsp.rdata = st_q.rel_dist;
        SEL_SPEED: st_d.rsp.rdata = st_q.speed;
        SEL_PRESET: st_d.rsp.rdata = st_q.scale;
        SEL_ACC: st_d.rsp.rdata = st_q.acc;
        SEL_DEC: st_d.rsp.rdata = st_q.dec;
        SEL_MODE: st_d.rsp.rdata = {16'h0000, st_q.mode};
        SEL_HSTATE: st_d.rsp.rdata = {30'h00000000, st_q.ref_ok, st_q.home_st == HOME_RUN};
        SEL_ACT: st_d.rsp.rdata = {31'h00000000, st_q.ref_ok};
        SEL_GOAL: st_d.rsp.rdata = st_q.off_tgt - st_q.scale;
        SEL_CUR: st_d.rsp.rdata = st_q.off_cur - st_q.scale;
        SEL_APOS: st_d.rsp.rdata = motor_pos - st_q.origin;
        default: st_d.rsp.err = 1'b1;
      endcase
    end
    // Writes act on receipt with no confirmation step.
    if (par_req.wr)
    begin
      case (wsel)
        SEL_ABS:
        begin
          st_d.abs_tgt = par_req.wdata;
          new_tgt = par_req.wdata + st_q.scale;
          start = 1'b1;
        end
        SEL_REL:
        begin
          st_d.rel_dist = par_req.wdata;
          new_tgt = st_q.off_cur + par_req.wdata;
          start = 1'b1;
        end
        SEL_SPEED:
          if ($signed(par_req.wdata) >= $signed(SPEED_MIN) &&
              $signed(par_req.wdata) <= $signed(SPEED_MAX))
            st_d.speed = par_req.wdata;
          else
            st_d.rsp.err = 1'b1;
        SEL_ACC:
          if ($signed(par_req.wdata) >= $signed(RAMP_MIN) &&
              $signed(par_req.wdata) <= $signed(RAMP_MAX))
            st_d.acc = par_req.wdata;
          else
            st_d.rsp.err = 1'b1;
        SEL_DEC:
          if ($signed(par_req.wdata) >= $signed(RAMP_MIN) &&
              $signed(par_req.wdata) <= $signed(RAMP_MAX))
            st_d.dec = par_req.wdata;
          else
            st_d.rsp.err = 1'b1;
        SEL_MODE: st_d.mode = par_req.wdata[15:0];
        SEL_PRESET: st_d.scale = st_q.off_cur - par_req.wdata;
        SEL_HSTART:
        begin
          st_d.home_st = HOME_RUN;
          st_d.ref_ok = 1'b0;
        end
        SEL_SSTART:
        begin
          st_d.origin = motor_pos;
          st_d.ref_ok = 1'b1;
          st_d.home_st = HOME_IDLE;
        end
        default: st_d.rsp.err = 1'b1;
      endcase
    end
    // The reference move ends on the rising edge of the reference switch.
    if (st_q.home_st == HOME_RUN && st_q.ref_s2 && !st_q.ref_s3)
    begin
      st_d.origin = motor_pos;
      st_d.ref_ok = 1'b1;
      st_d.home_st = HOME_IDLE;
    end
    // Offset motion. A target written outside gear mode is stored but not run.
    if (start && gear_active)
    begin
      st_d.off_tgt = new_tgt;
      st_d.status = 16'h0000;
      if (jump)
      begin
        st_d.off_cur = new_tgt;
        st_d.off_st = OFF_IDLE;
        st_d.status[ST_REACHED] = 1'b1;
        st_d.status[ST_END] = 1'b1;
      end
      else
      begin
        st_d.off_st = OFF_RAMP;
        st_d.vel = 48'h000000000000;
        st_d.frac = 48'h000000000000;
        st_d.tick = 16'h0000;
      end
    end
    else if (st_q.off_st == OFF_RAMP)
    begin
      if (!gear_active)
      begin
        st_d.off_st = OFF_IDLE;
        st_d.vel = 48'h000000000000;
        st_d.status[ST_END] = 1'b1;
      end
      else if (st_q.err_s2 != 8'h00)
      begin
        st_d.off_st = OFF_IDLE;
        st_d.vel = 48'h000000000000;
        st_d.status[7:0] = st_q.err_s2 & 8'hEF;
        st_d.status[ST_END] = 1'b1;
        st_d.status[ST_ERR] = 1'b1;
      end
      else if (!gear_proc_en)
      begin
        st_d.off_cur = st_q.off_tgt;
        st_d.off_st = OFF_IDLE;
        st_d.vel = 48'h000000000000;
        st_d.status[ST_REACHED] = 1'b1;
        st_d.status[ST_END] = 1'b1;
      end
      else if (st_q.tick == TICK_CYCLES - 16'h0001)
      begin
        // Velocity is in milli-rpm, so one ramp step per millisecond adds the setting.
        st_d.tick = 16'h0000;
        diff = st_q.off_tgt - st_q.off_cur;
        rem = diff[31] ? 33'(-{diff[31], diff}) : {1'b0, diff};
        vmax = 48'(st_q.speed) * MRPM_PER_RPM;
        brake_lhs = 96'(rem) * BRAKE_K * 96'(st_q.dec);
        brake_rhs = 96'(st_q.vel) * 96'(st_q.vel) * 96'(INC_PER_REV);
        // The braking test uses products only so no divider by a setting is needed.
        if (brake_lhs <= brake_rhs)
          st_d.vel = (st_q.vel > 48'(st_q.dec) + MRPM_PER_RPM) ?
            st_q.vel - 48'(st_q.dec) : MRPM_PER_RPM;
        else if (st_q.vel + 48'(st_q.acc) < vmax)
          st_d.vel = st_q.vel + 48'(st_q.acc);
        else
          st_d.vel = vmax;
        step_sum = st_q.frac + st_d.vel * INC_PER_REV;
        nsteps = step_sum / STEP_DIV;
        st_d.frac = step_sum % STEP_DIV;
        if (nsteps >= 48'(rem))
        begin
          st_d.off_cur = st_q.off_tgt;
          st_d.off_st = OFF_IDLE;
          st_d.vel = 48'h000000000000;
          st_d.status[ST_REACHED] = 1'b1;
          st_d.status[ST_END] = 1'b1;
        end
        else if (diff[31])
          st_d.off_cur = st_q.off_cur - nsteps[31:0];
        else
          st_d.off_cur = st_q.off_cur + nsteps[31:0];
      end
      else
        st_d.tick = st_q.tick + 16'h0001;
    end
    st_d.setpoint = st_q.gear_acc + (gear_active ? st_q.off_cur : 32'h00000000);
    if (srst)
    begin
      st_d = '0;
      st_d.speed = SPEED_RST;
      st_d.acc = RAMP_RST;
      st_d.dec = RAMP_RST;
      st_d.off_st = OFF_IDLE;
      st_d.home_st = HOME_IDLE;
    end
  end

  always_ff @(posedge clk)
  begin
    st_q <= st_d;
  end

  assign par_rsp = st_q.rsp;
  assign pos_setpoint = st_q.setpoint;
  assign home_active = st_q.home_st == HOME_RUN;
  assign ref_valid = st_q.ref_ok;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_abs_write;
    par_req.wr && par_req.idx == IDX_GEAR && par_req.six == SIX_ABS;
  endsequence

  sequence s_jump_ready;
    gear_active && (!st_q.mode[0] || !gear_proc_en);
  endsequence

  a_par_ack_next: assert property ((par_req.wr || par_req.rd) |=> par_rsp.ack)
    else $error("access not acknowledged next cycle");
  a_jump_sets_target: assert property (s_abs_write and s_jump_ready |=>
      st_q.off_cur == $past(par_req.wdata) + $past(st_q.scale) && st_q.status[ST_REACHED])
    else $error("jump offset not applied at once");
  a_abort_on_exit: assert property (st_q.off_st == OFF_RAMP && !gear_active && !par_req.wr
      |=> st_q.off_st == OFF_IDLE && st_q.status[ST_END])
    else $error("offset move not aborted when gear mode left");
  a_preset_no_move: assert property (par_req.wr && par_req.idx == IDX_GEAR &&
      par_req.six == SIX_PRESET && st_q.off_st == OFF_IDLE |=> $stable(st_q.off_cur))
    else $error("scale preset moved the offset");
  a_setp_origin: assert property (par_req.wr && par_req.idx == IDX_HOME &&
      par_req.six == SIX_SETP_START |=> st_q.origin == $past(motor_pos) && ref_valid)
    else $error("dimension set did not take motor position");
  a_speed_cap: assert property (st_q.vel <= 48'(st_q.speed) * MRPM_PER_RPM)
    else $error("offset velocity above target speed");
  a_state_readonly: assert property (par_req.wr && par_req.idx == IDX_GEAR &&
      par_req.six == SIX_STATE |=> par_rsp.err)
    else $error("write to status word not refused");
  a_ramp_ends_flag: assert property (st_q.off_st == OFF_RAMP ##1 st_q.off_st == OFF_IDLE
      |-> st_q.status[ST_END] || $past(par_req.wr))
    else $error("offset end flag missing");
  a_ref_switch_origin: assert property (home_active && st_q.ref_s2 && !st_q.ref_s3 && !par_req.wr
      |=> ref_valid && !home_active)
    else $error("reference move did not finish on switch");
  a_setpoint_sum: assert property (gear_active |=>
      pos_setpoint == $past(st_q.gear_acc) + $past(st_q.off_cur))
    else $error("setpoint lacks offset");
endmodule

// *** dv/goh_master.sv ***
`timescale 1ns/10ps
module goh_master import goh_pkg::*; (
  // Clock
  input wire logic clk,
  // Parameter channel
  output goh_par_req_t par_req,
  input wire goh_par_rsp_t par_rsp
);
  initial par_req = '0;

  // One access: the strobe is seen at one edge and the answer is taken one edge later.
  // Released address and data lines show the inverse, so a stale value is never read.
  task automatic xfer(input logic w, input logic [7:0] i, s, input logic [31:0] d,
    output goh_par_rsp_t r);
    @(posedge clk);
    par_req <= '{wr: w, rd: !w, idx: i, six: s, wdata: d};
    @(posedge clk);
    par_req <= '{wr: 1'b0, rd: 1'b0, idx: ~i, six: ~s, wdata: ~d};
    @(posedge clk);
    r = par_rsp;
  endtask
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
`define CHK(a, e) \
  begin \
    tests_run++; \
    if ((a) !== (e)) \
    begin \
      n_mismatch++; \
      $display("[ERR] %0t got %h exp %h", $time, (a), (e)); \
    end \
  end
module tb_top import goh_pkg::*; ;
  logic clk = 1'b0;
  logic srst = 1'b1;
  goh_par_req_t par_req;
  goh_par_rsp_t par_rsp;
  logic gear_active = 1'b0;
  logic gear_proc_en = 1'b1;
  logic gear_num_neg = 1'b0;
  logic ref_step = 1'b0;
  logic ref_step_dir = 1'b0;
  logic [31:0] motor_pos = 32'h0;
  logic [7:0] err_pins = 8'h00;
  logic ref_switch = 1'b0;
  logic [31:0] pos_setpoint;
  logic home_active;
  logic ref_valid;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [7:0] rs_six [6] = '{SIX_SPEED, SIX_ACC, SIX_DEC, SIX_ABS, SIX_REL, SIX_MODE};
  logic [31:0] rs_val [6] = '{SPEED_RST, RAMP_RST, RAMP_RST, 32'h0, 32'h0, 32'h0};

  always #10 clk = ~clk;

  goh_offset_homing #(.TICK_CYCLES(16'h0014)) u_dut (
    .clk(clk), .srst(srst), .par_req(par_req), .par_rsp(par_rsp),
    .gear_active(gear_active), .gear_proc_en(gear_proc_en), .gear_num_neg(gear_num_neg),
    .ref_step(ref_step), .ref_step_dir(ref_step_dir), .motor_pos(motor_pos),
    .err_pins(err_pins), .ref_switch(ref_switch), .pos_setpoint(pos_setpoint),
    .home_active(home_active), .ref_valid(ref_valid)
  );

  goh_master u_mst (.clk(clk), .par_req(par_req), .par_rsp(par_rsp));

  task automatic results;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic bad;
    n_mismatch++;
    $display("[ERR] %0t wait expired", $time);
    results();
  endtask

  task automatic wrx(input logic [7:0] i, s, input logic [31:0] d, input logic e);
    goh_par_rsp_t r;
    u_mst.xfer(1'b1, i, s, d, r);
    `CHK({r.ack, r.err}, {1'b1, e})
  endtask

  task automatic rdx(input logic [7:0] i, s, input logic [31:0] x);
    goh_par_rsp_t r;
    u_mst.xfer(1'b0, i, s, 32'h0, r);
    `CHK({r.ack, r.err, r.rdata}, {2'b10, x})
  endtask

  // Polls the status word; a ramp that never ends closes the run.
  task automatic wait_end;
    goh_par_rsp_t r;
    int n;
    n = 0;
    r = '0;
    while (r.rdata[ST_END] !== 1'b1 && n < 5000)
    begin
      u_mst.xfer(1'b0, IDX_GEAR, SIX_STATE, 32'h0, r);
      n++;
    end
    if (r.rdata[ST_END] !== 1'b1)
      bad();
  endtask

  task automatic wait_ref;
    int n;
    n = 0;
    while (ref_valid !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (ref_valid !== 1'b1)
      bad();
  endtask

  task automatic pulse(input logic dir, input int n);
    repeat (n)
    begin
      @(posedge clk);
      ref_step <= 1'b1;
      ref_step_dir <= dir;
    end
    @(posedge clk);
    ref_step <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    `CHK({home_active, ref_valid, pos_setpoint}, 34'h0)
    for (int k = 0; k < 6; k++)
      rdx(IDX_GEAR, rs_six[k], rs_val[k]);
    wrx(IDX_GEAR, SIX_SPEED, 32'h0, 1'b1);
    wrx(IDX_GEAR, SIX_SPEED, 32'h2EE1, 1'b1);
    wrx(IDX_GEAR, SIX_SPEED, SPEED_MAX, 1'b0);
    rdx(IDX_GEAR, SIX_SPEED, SPEED_MAX);
    wrx(IDX_GEAR, SIX_ACC, 32'h3B, 1'b1);
    wrx(IDX_GEAR, SIX_ACC, 32'h1E8481, 1'b1);
    wrx(IDX_GEAR, SIX_ACC, RAMP_MAX, 1'b0);
    wrx(IDX_GEAR, SIX_DEC, 32'h3B, 1'b1);
    wrx(IDX_GEAR, SIX_DEC, RAMP_MAX, 1'b0);
    wrx(IDX_GEAR, 8'h04, 32'h1, 1'b1);
    wrx(IDX_GEAR, SIX_STATE, 32'h1, 1'b1);
    wrx(IDX_HOME, SIX_HOME_STATE, 32'h1, 1'b1);
    @(posedge clk);
    gear_active <= 1'b1;
    wrx(IDX_GEAR, SIX_ABS, 32'h64, 1'b0);
    rdx(IDX_GEAR, SIX_STATE, 32'h6000);
    `CHK(pos_setpoint, 32'h64)
    wrx(IDX_GEAR, SIX_REL, 32'h32, 1'b0);
    rdx(IDX_STAT, SIX_GOAL, 32'h96);
    `CHK(pos_setpoint, 32'h96)
    wrx(IDX_GEAR, SIX_PRESET, 32'h3E8, 1'b0);
    rdx(IDX_STAT, SIX_GOAL, 32'h3E8);
    rdx(IDX_STAT, SIX_CUR, 32'h3E8);
    `CHK(pos_setpoint, 32'h96)
    wrx(IDX_GEAR, SIX_MODE, 32'h1, 1'b0);
    wrx(IDX_GEAR, SIX_REL, 32'h4E20, 1'b0);
    rdx(IDX_GEAR, SIX_STATE, 32'h0);
    wait_end();
    rdx(IDX_GEAR, SIX_STATE, 32'h6000);
    `CHK(pos_setpoint, 32'h4EB6)
    @(posedge clk);
    gear_proc_en <= 1'b0;
    wrx(IDX_GEAR, SIX_REL, 32'hA, 1'b0);
    rdx(IDX_GEAR, SIX_STATE, 32'h6000);
    `CHK(pos_setpoint, 32'h4EC0)
    @(posedge clk);
    gear_proc_en <= 1'b1;
    wrx(IDX_GEAR, SIX_ACC, RAMP_MIN, 1'b0);
    wrx(IDX_GEAR, SIX_REL, 32'h186A0, 1'b0);
    @(posedge clk);
    err_pins <= 8'h15;
    repeat (4) @(posedge clk);
    rdx(IDX_GEAR, SIX_STATE, 32'hC005);
    @(posedge clk);
    err_pins <= 8'h00;
    wrx(IDX_GEAR, SIX_REL, 32'h186A0, 1'b0);
    @(posedge clk);
    gear_active <= 1'b0;
    repeat (2) @(posedge clk);
    rdx(IDX_GEAR, SIX_STATE, 32'h4000);
    `CHK(pos_setpoint, 32'h0)
    pulse(1'b0, 3);
    `CHK(pos_setpoint, 32'h3)
    gear_num_neg <= 1'b1;
    pulse(1'b0, 2);
    `CHK(pos_setpoint, 32'h1)
    @(posedge clk);
    motor_pos <= 32'h1F4;
    wrx(IDX_HOME, SIX_HOME_START, 32'h1, 1'b0);
    `CHK({home_active, ref_valid}, 2'b10)
    rdx(IDX_HOME, SIX_HOME_STATE, 32'h1);
    @(posedge clk);
    ref_switch <= 1'b1;
    wait_ref();
    @(posedge clk);
    motor_pos <= 32'h2BC;
    rdx(IDX_STAT, SIX_ABS_POS, 32'hC8);
    rdx(IDX_HOME, SIX_ACT_MODE, 32'h1);
    rdx(IDX_HOME, SIX_HOME_STATE, 32'h2);
    @(posedge clk);
    ref_switch <= 1'b0;
    motor_pos <= 32'h384;
    wrx(IDX_HOME, SIX_SETP_START, 32'h1, 1'b0);
    rdx(IDX_STAT, SIX_ABS_POS, 32'h0);
    `CHK(ref_valid, 1'b1)
    results();
  end
endmodule
